// ### rbe_consts.vh
// Constants for the read-buffer echo and error-history command block.
// Summary of operation
// - Echo read returns the bytes last stored by an echo-mode buffer write.
// - Echo read without any earlier echo write ends in Check Condition, Illegal Request.
// - Echo read sends the lesser of allocation length and stored byte count.
// - Echo read ignores upper two allocation bytes, buffer id and offset.
// - Echo storage is separate from the general data buffer.
// - Echo descriptor mode returns the lesser of allocation length and four bytes.
// - Descriptor byte 0 bit 0, echo overwrite flag, reads zero: one shared buffer.
// - Descriptor bytes 2-3 give echo size, MSB first, multiple of four.
// - Expander-communications mode is handled exactly like an echo read.
// - History ids 00h-03h return directory at offset 0; snapshot and nexus side effects.
// - Id 10h returns history at offsets below the held length; FEh/FFh clear nexus/snapshot.
// - Ids 02h, 03h escape the nexus constraint; 04h-0Fh, F0h-FDh reserved.
// - Constrained id from another nexus with snapshot present: operation in progress.
// - Bad history offset ends in Illegal Request, invalid CDB field.
// - Unsupported id from the owning nexus ends in invalid CDB field.
// - Directory: vendor id 0-7, version 8, length 30-31, entries from 32.
// - Entry: id in byte 0, zeros 1-3, 32-bit maximum length in 4-7.
// - History data comes from the snapshot starting at the requested offset.
// - Held history never exceeds the advertised maximum length.
// - Every directory action at offset 0 returns the directory when nexus rules allow.
// - Five-bit mode is decoded; anything outside the supported set is unsupported.
`ifndef RBE_CONSTS_VH
`define RBE_CONSTS_VH
`define MODE_ECHO_RD 5'h0a
`define MODE_ECHO_DESC 5'h0b
`define MODE_EXP_COMM 5'h1a
`define MODE_HIST 5'h1c
`define ECHO_CAP 7'h40
`define ECHO_CAP_RPT 16'h0040
`define HIST_ID 8'h10
`define HIST_MAXLEN_RST 16'h0100
`define DIR_TOTAL 16'h0048
`define DIR_BODY_LEN 8'h28
// Vendor identifier bytes of the directory; the value is arbitrary.
`define DIR_VENDOR 64'h564e445230303030
`define VERSION_RST 8'h01
`define SENSE_NONE 4'h0
`define SENSE_ILLEGAL 4'h5
`define ASC_INV_FIELD 8'h24
`define ASC_NO_ECHO 8'h2c
`define ASC_OP_BUSY 8'h16
`define REG_HISTLEN 4'h0
`define REG_VERSION 4'h4
`define REG_STATUS 4'h8
`define REG_ECHOCNT 4'hc
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### rbe_read_buffer.v
// Read-buffer echo and error-history command interpreter with AXI4-Lite registers.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rbe_consts.vh"
module rbe_read_buffer (
  // Clock, reset and enable.
  input wire clock,
  input wire arst_n,
  input wire clkEn,
  // Command descriptor fields.
  input wire cmdValid,
  input wire [4:0] cmdMode,
  input wire [7:0] cmdBufId,
  input wire [23:0] cmdOffset,
  input wire [23:0] cmdAllocLen,
  input wire [7:0] cmdNexus,
  output wire cmdReady,
  // Echo-mode buffer write stream.
  input wire ewStart,
  input wire ewValid,
  input wire [7:0] ewData,
  // Data-in byte stream.
  output wire dinValid,
  output wire [7:0] dinData,
  output wire dinLast,
  input wire dinReady,
  // Completion status.
  output wire doneValid,
  output wire doneCheck,
  output wire [3:0] doneSense,
  output wire [7:0] doneAsc,
  // AXI4-Lite register slave.
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);

  localparam ST_IDLE = 2'd0;
  localparam ST_SEND = 2'd1;
  localparam ST_DONE = 2'd2;
  localparam SRC_ECHO = 2'd0;
  localparam SRC_DESC = 2'd1;
  localparam SRC_DIR = 2'd2;
  localparam SRC_HIST = 2'd3;

  ////////////////////////////////////////////////////////////////////////////
  reg [1:0] state_ff;
  reg [1:0] src_ff;
  reg [15:0] len_ff;
  reg [15:0] idx_ff;
  reg [15:0] offBase_ff;
  reg cmdReady_ff;
  reg dinValid_ff;
  reg [7:0] dinData_ff;
  reg dinLast_ff;
  reg doneValid_ff;
  reg doneCheck_ff;
  reg [3:0] doneSense_ff;
  reg [7:0] doneAsc_ff;
  reg echoValid_ff;
  reg [6:0] echoCnt_ff;
  reg [7:0] echoMem [0:63];
  reg nexusValid_ff;
  reg [7:0] nexusId_ff;
  reg snapValid_ff;
  reg [7:0] snapTag_ff;
  reg [7:0] tagCnt_ff;
  reg [15:0] histLen_ff;
  reg [7:0] version_ff;
  reg awHeld_ff;
  reg wHeld_ff;
  reg [3:0] awAddr_ff;
  reg [31:0] wData_ff;
  reg [3:0] wStrb_ff;
  reg bValid_ff;
  reg [1:0] bResp_ff;
  reg rValid_ff;
  reg [31:0] rData_ff;
  reg [1:0] rResp_ff;

  ////////////////////////////////////////////////////////////////////////////
  function [15:0] min16;
    input [15:0] a;
    input [15:0] b;
    begin
      min16 = (a < b) ? a : b;
    end
  endfunction

  // Directory image; entries for ids 00h-03h and the single history id 10h.
  function [7:0] dirByte;
    input [15:0] i;
    input [7:0] ver;
    input [15:0] hl;
    reg [15:0] rel;
    reg [15:0] maxLen;
    reg [63:0] vend;
    begin
      rel = i - 16'd32;
      maxLen = (rel[15:3] < 13'd4) ? `DIR_TOTAL : hl;
      vend = `DIR_VENDOR >> {i[2:0] ^ 3'd7, 3'd0};
      dirByte = 8'h00;
      if (i < 16'd8) begin
        dirByte = vend[7:0];
      end else if (i == 16'd8) begin
        dirByte = ver;
      end else if (i == 16'd31) begin
        dirByte = `DIR_BODY_LEN;
      end else if (i >= 16'd32) begin
        case (rel[2:0])
          3'd0: dirByte = (rel[15:3] < 13'd4) ? {6'h00, rel[4:3]} : `HIST_ID;
          3'd6: dirByte = maxLen[15:8];
          3'd7: dirByte = maxLen[7:0];
          default: dirByte = 8'h00;
        endcase
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  wire isEcho = (cmdMode == `MODE_ECHO_RD) || (cmdMode == `MODE_EXP_COMM);
  wire isDesc = (cmdMode == `MODE_ECHO_DESC);
  wire isHist = (cmdMode == `MODE_HIST);
  wire freeId = (cmdBufId == 8'h02) || (cmdBufId == 8'h03);
  wire blocked = !freeId && nexusValid_ff && (cmdNexus != nexusId_ff) && snapValid_ff;
  wire dirId = (cmdBufId <= 8'h03);
  wire clrId = (cmdBufId >= 8'hfe);
  wire histId = (cmdBufId == `HIST_ID);
  wire histOffBad = ({8'h00, histLen_ff} <= cmdOffset);
  wire [15:0] allocClip = (cmdAllocLen[23:16] != 8'h00) ? 16'hffff : cmdAllocLen[15:0];
  wire [15:0] histAvail = histLen_ff - cmdOffset[15:0];
  wire [15:0] echoLen = min16({8'h00, cmdAllocLen[7:0]}, {9'h000, echoCnt_ff});
  wire [15:0] descLen = min16(allocClip, 16'd4);
  wire [15:0] dirLen = min16(allocClip, `DIR_TOTAL);
  wire [15:0] histXfer = min16(allocClip, histAvail);
  wire [15:0] histIdx = offBase_ff + idx_ff;
  wire [15:0] capRpt = `ECHO_CAP_RPT & 16'hfffc;
  reg [7:0] curByte;

  always @* begin
    case (src_ff)
      SRC_ECHO: curByte = echoMem[idx_ff[5:0]];
      SRC_DESC: begin
        case (idx_ff[1:0])
          2'd2: curByte = capRpt[15:8];
          2'd3: curByte = capRpt[7:0];
          default: curByte = 8'h00;
        endcase
      end
      SRC_DIR: curByte = dirByte(idx_ff, version_ff, histLen_ff);
      SRC_HIST: curByte = histIdx[7:0] ^ snapTag_ff;
      default: curByte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Echo storage is only the last write; a write longer than the buffer drops the excess.
  always @(posedge clock) begin
    if (clkEn && ewValid && !ewStart && (echoCnt_ff < `ECHO_CAP)) begin
      echoMem[echoCnt_ff[5:0]] <= ewData;
    end
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      echoValid_ff <= 1'b0;
      echoCnt_ff <= 7'h00;
      tagCnt_ff <= 8'h00;
    end else if (clkEn) begin
      tagCnt_ff <= tagCnt_ff + 8'h01;
      if (ewStart) begin
        echoValid_ff <= 1'b1;
        echoCnt_ff <= 7'h00;
      end else if (ewValid && (echoCnt_ff < `ECHO_CAP)) begin
        echoCnt_ff <= echoCnt_ff + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
      src_ff <= SRC_ECHO;
      len_ff <= 16'h0000;
      idx_ff <= 16'h0000;
      offBase_ff <= 16'h0000;
      cmdReady_ff <= 1'b1;
      dinValid_ff <= 1'b0;
      dinData_ff <= 8'h00;
      dinLast_ff <= 1'b0;
      doneValid_ff <= 1'b0;
      doneCheck_ff <= 1'b0;
      doneSense_ff <= `SENSE_NONE;
      doneAsc_ff <= 8'h00;
      nexusValid_ff <= 1'b0;
      nexusId_ff <= 8'h00;
      snapValid_ff <= 1'b0;
      snapTag_ff <= 8'h00;
    end else if (clkEn) begin
      doneValid_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (cmdValid) begin
            cmdReady_ff <= 1'b0;
            idx_ff <= 16'h0000;
            offBase_ff <= cmdOffset[15:0];
            doneCheck_ff <= 1'b1;
            doneSense_ff <= `SENSE_ILLEGAL;
            doneAsc_ff <= `ASC_INV_FIELD;
            state_ff <= ST_DONE;
            if (isEcho) begin
              if (!echoValid_ff) begin
                doneAsc_ff <= `ASC_NO_ECHO;
              end else begin
                src_ff <= SRC_ECHO;
                len_ff <= echoLen;
                state_ff <= ST_SEND;
              end
            end else if (isDesc) begin
              src_ff <= SRC_DESC;
              len_ff <= descLen;
              state_ff <= ST_SEND;
            end else if (isHist) begin
              if (blocked) begin
                doneAsc_ff <= `ASC_OP_BUSY;
              end else if (dirId) begin
                if (cmdOffset == 24'h000000) begin
                  if (cmdBufId[0]) begin
                    snapValid_ff <= 1'b1;
                    snapTag_ff <= tagCnt_ff;
                  end
                  if (cmdBufId[1]) begin
                    nexusValid_ff <= 1'b1;
                    nexusId_ff <= cmdNexus;
                  end
                  src_ff <= SRC_DIR;
                  len_ff <= dirLen;
                  state_ff <= ST_SEND;
                end
              end else if (clrId) begin
                nexusValid_ff <= 1'b0;
                if (cmdBufId[0]) begin
                  snapValid_ff <= 1'b0;
                end
                len_ff <= 16'h0000;
                state_ff <= ST_SEND;
              end else if (histId && !histOffBad) begin
                if (!snapValid_ff) begin
                  snapValid_ff <= 1'b1;
                  snapTag_ff <= tagCnt_ff;
                end
                src_ff <= SRC_HIST;
                len_ff <= histXfer;
                state_ff <= ST_SEND;
              end
              // Reserved, unsupported ids and bad offsets fall through as invalid field.
            end
            // Any other mode stays an invalid-field check condition.
            if (isHist && !blocked && !dirId && !clrId && !histId) begin
              doneAsc_ff <= `ASC_INV_FIELD;
            end
          end
        end
        ST_SEND: begin
          doneCheck_ff <= 1'b0;
          doneSense_ff <= `SENSE_NONE;
          doneAsc_ff <= 8'h00;
          if (!dinValid_ff || dinReady) begin
            if (idx_ff < len_ff) begin
              dinValid_ff <= 1'b1;
              dinData_ff <= curByte;
              dinLast_ff <= (idx_ff == len_ff - 16'h0001);
              idx_ff <= idx_ff + 16'h0001;
            end else begin
              dinValid_ff <= 1'b0;
              dinLast_ff <= 1'b0;
              state_ff <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          doneValid_ff <= 1'b1;
          cmdReady_ff <= 1'b1;
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write address and data may arrive in either order; each is held until both are in.
  wire doWrite = awHeld_ff && wHeld_ff && !bValid_ff;
  wire wrMapped = (awAddr_ff == `REG_HISTLEN) || (awAddr_ff == `REG_VERSION) ||
    (awAddr_ff == `REG_STATUS) || (awAddr_ff == `REG_ECHOCNT);

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= 4'h0;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
      bValid_ff <= 1'b0;
      bResp_ff <= `RESP_OKAY;
      histLen_ff <= `HIST_MAXLEN_RST;
      version_ff <= `VERSION_RST;
      rValid_ff <= 1'b0;
      rData_ff <= 32'h00000000;
      rResp_ff <= `RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_awvalid && !awHeld_ff) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_ff) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        bValid_ff <= 1'b1;
        bResp_ff <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
        if (awAddr_ff == `REG_HISTLEN) begin
          if (wStrb_ff[0]) histLen_ff[7:0] <= wData_ff[7:0];
          if (wStrb_ff[1]) histLen_ff[15:8] <= wData_ff[15:8];
        end
        if ((awAddr_ff == `REG_VERSION) && wStrb_ff[0]) begin
          version_ff <= wData_ff[7:0];
        end
      end else if (bValid_ff && s_axi_bready) begin
        bValid_ff <= 1'b0;
      end
      if (s_axi_arvalid && !rValid_ff) begin
        rValid_ff <= 1'b1;
        rResp_ff <= `RESP_OKAY;
        case (s_axi_araddr)
          `REG_HISTLEN: rData_ff <= {16'h0000, histLen_ff};
          `REG_VERSION: rData_ff <= {24'h000000, version_ff};
          `REG_STATUS: rData_ff <= {16'h0000, nexusId_ff, 5'h00, snapValid_ff,
            nexusValid_ff, echoValid_ff};
          `REG_ECHOCNT: rData_ff <= {25'h0000000, echoCnt_ff};
          default: begin
            rData_ff <= 32'h00000000;
            rResp_ff <= `RESP_SLVERR;
          end
        endcase
      end else if (rValid_ff && s_axi_rready) begin
        rValid_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign cmdReady = cmdReady_ff;
  assign dinValid = dinValid_ff;
  assign dinData = dinData_ff;
  assign dinLast = dinLast_ff;
  assign doneValid = doneValid_ff;
  assign doneCheck = doneCheck_ff;
  assign doneSense = doneSense_ff;
  assign doneAsc = doneAsc_ff;
  assign s_axi_awready = !awHeld_ff;
  assign s_axi_wready = !wHeld_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_arready = !rValid_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;

endmodule

// ### rbe_read_buffer_assertions.sv
// Checker on the command, data-in and status ports of the read-buffer block.
`timescale 1ns/1ps
`include "rbe_consts.vh"
module rbe_read_buffer_assertions (
  // Clock and reset.
  input wire clock,
  input wire arst_n,
  // Command side.
  input wire clkEn,
  input wire cmdValid,
  input wire cmdReady,
  input wire [4:0] cmdMode,
  input wire [23:0] cmdAllocLen,
  // Data-in and status side.
  input wire dinValid,
  input wire [7:0] dinData,
  input wire dinLast,
  input wire dinReady,
  input wire doneValid,
  input wire doneCheck,
  input wire [3:0] doneSense,
  input wire [7:0] doneAsc
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence take_s(m);
    clkEn && cmdValid && cmdReady && cmdMode == m;
  endsequence
  sequence quiet_s;
    !dinValid [*2];
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  mode_reject_a: assert property (take_s(cmdMode) ##0 !(cmdMode inside {`MODE_ECHO_RD,
    `MODE_ECHO_DESC, `MODE_EXP_COMM, `MODE_HIST}) |-> ##2 doneValid && doneCheck &&
    doneSense == `SENSE_ILLEGAL && doneAsc == `ASC_INV_FIELD) else $error("bad mode accepted");
  desc_flag_a: assert property (take_s(`MODE_ECHO_DESC) ##0 cmdAllocLen != 24'h0 |->
    ##2 dinValid && !dinData[0]) else $error("descriptor flag not zero");
  desc_empty_a: assert property (take_s(`MODE_ECHO_DESC) ##0 cmdAllocLen == 24'h0 |=>
    quiet_s ##1 doneValid && !doneCheck) else $error("empty descriptor misbehaved");
  din_hold_a: assert property (dinValid && !dinReady |=> dinValid && $stable(dinData) &&
    $stable(dinLast)) else $error("data-in byte changed while stalled");
  last_valid_a: assert property (dinLast |-> dinValid) else $error("last without valid");
  done_pulse_a: assert property (doneValid |=> !doneValid) else $error("done too long");
  busy_after_a: assert property (take_s(cmdMode) |=> !cmdReady) else $error("ready after take");
  ready_done_a: assert property ($rose(cmdReady) |-> doneValid) else $error("ready w/o done");
endmodule
bind rbe_read_buffer rbe_read_buffer_assertions chk (.clock(clock), .arst_n(arst_n),
  .clkEn(clkEn), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdMode(cmdMode),
  .cmdAllocLen(cmdAllocLen), .dinValid(dinValid), .dinData(dinData), .dinLast(dinLast),
  .dinReady(dinReady), .doneValid(doneValid), .doneCheck(doneCheck), .doneSense(doneSense),
  .doneAsc(doneAsc));

// ### rbe_host_sink.sv
// Initiator model that takes data-in bytes, stalling on a fixed pattern when asked.
`timescale 1ns/1ps
module rbe_host_sink (
  // Clock and reset.
  input wire clock,
  input wire arst_n,
  // Pacing.
  input wire stall,
  // Data-in stream.
  input wire dinValid,
  input wire [7:0] dinData,
  input wire dinLast,
  output logic dinReady
);
  logic [2:0] pace_ff;
  logic [7:0] got[$];
  int lastPos[$];
  // A fixed stall pattern keeps a failing run repeatable.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pace_ff <= 3'h0;
      dinReady <= 1'b0;
    end else begin
      pace_ff <= pace_ff + 3'h1;
      dinReady <= !stall || (pace_ff[0] ^ pace_ff[2]);
      if (dinValid && dinReady) begin
        if (dinLast) lastPos.push_back(got.size());
        got.push_back(dinData);
      end
    end
  end
endmodule

// ### rbe_read_buffer_test.sv
// Self-checking bench for the read-buffer echo and error-history block.
`timescale 1ns/1ps
`include "rbe_consts.vh"
module rbe_read_buffer_test;
  logic clock, arst_n, cmdValid, ewStart, ewValid, stall;
  logic [4:0] cmdMode;
  logic [7:0] cmdBufId, cmdNexus, ewData;
  logic [23:0] cmdOffset, cmdAllocLen;
  wire cmdReady, dinValid, dinLast, dinReady, doneValid, doneCheck;
  wire [7:0] dinData, doneAsc;
  wire [3:0] doneSense;
  logic [3:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, seed, rd, r;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic [7:0] em[64];
  logic [7:0] ex[$];
  logic [4:0] badModes[4] = '{5'h00, 5'h02, 5'h1f, 5'h0c};
  int num_errors, n_checks, cyc, ec;
  logic [1:0] wantResp;
  rbe_read_buffer dut (.clock(clock), .arst_n(arst_n), .clkEn(1'b1), .cmdValid(cmdValid),
    .cmdMode(cmdMode), .cmdBufId(cmdBufId), .cmdOffset(cmdOffset), .cmdAllocLen(cmdAllocLen),
    .cmdNexus(cmdNexus), .cmdReady(cmdReady), .ewStart(ewStart), .ewValid(ewValid),
    .ewData(ewData), .dinValid(dinValid), .dinData(dinData), .dinLast(dinLast),
    .dinReady(dinReady), .doneValid(doneValid), .doneCheck(doneCheck), .doneSense(doneSense),
    .doneAsc(doneAsc), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  rbe_host_sink sink (.clock(clock), .arst_n(arst_n), .stall(stall), .dinValid(dinValid),
    .dinData(dinData), .dinLast(dinLast), .dinReady(dinReady));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int least(int a, int b);
    return a < b ? a : b;
  endfunction
  task automatic conclude();
    $display("checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmpV(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  // Sense fields are only meaningful with a check condition, so good status masks them.
  task automatic cmpSt(input logic ck, input logic [7:0] asc);
    cmpV({doneCheck, ck ? doneSense : 4'h0, ck ? doneAsc : 8'h0}, {ck, ck ? 4'h5 : 4'h0, asc});
  endtask
  task automatic cmpRx();
    cmpV(sink.got.size(), ex.size());
    foreach (ex[i]) if (i < sink.got.size()) cmpV(sink.got[i], ex[i]);
    cmpV(sink.lastPos.size(), ex.size() != 0);
    if (sink.lastPos.size() == 1 && ex.size() != 0) cmpV(sink.lastPos[0], ex.size() - 1);
  endtask
  task automatic axiWr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmpV(s_axi_bresp, wantResp);
  endtask
  task automatic axiRd(input logic [3:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    cmpV(s_axi_rresp, wantResp);
  endtask
  task automatic runCmd(input logic [4:0] m, input logic [7:0] id, input logic [23:0] off,
    input logic [23:0] al, input logic [7:0] nx);
    @(posedge clock);
    {cmdValid, cmdMode, cmdBufId, cmdOffset, cmdAllocLen, cmdNexus} <= {1'b1, m, id, off, al, nx};
    sink.got.delete();
    sink.lastPos.delete();
    do @(posedge clock); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
    do @(posedge clock); while (doneValid !== 1'b1);
  endtask
  task automatic echoWrite(input int n);
    logic [7:0] b;
    @(posedge clock);
    ewStart <= 1'b1;
    for (int i = 0; i < n; i++) begin
      b = rnd();
      if (i < 64) em[i] = b;
      @(posedge clock);
      {ewStart, ewValid, ewData} <= {2'h1, b};
    end
    @(posedge clock);
    ewValid <= 1'b0;
    ec = least(n, 64);
  endtask
  task automatic echoRead(input logic [4:0] m, input logic [23:0] al);
    r = rnd();
    runCmd(m, r[7:0], r[31:8], al, 8'h07);
    ex.delete();
    for (int i = 0; i < least(al[7:0], ec); i++) ex.push_back(em[i]);
    cmpRx();
    cmpSt(1'b0, 8'h0);
  endtask
  task automatic hist(input logic [7:0] id, input logic [23:0] off, input logic [7:0] nx);
    runCmd(`MODE_HIST, id, off, 24'hff, nx);
  endtask
  task automatic chkDir();
    int b;
    logic [63:0] vend;
    vend = `DIR_VENDOR;
    cmpV(sink.got.size(), 72);
    if (sink.got.size() == 72) begin
      cmpV({sink.got[0], sink.got[1], sink.got[2], sink.got[3]}, vend[63:32]);
      cmpV({sink.got[4], sink.got[5], sink.got[6], sink.got[7]}, vend[31:0]);
      cmpV({sink.got[8], sink.got[30], sink.got[31]}, 24'h5a0028);
      for (int k = 0; k < 5; k++) begin
        b = 32 + 8 * k;
        cmpV({sink.got[b], sink.got[b+1], sink.got[b+2], sink.got[b+3]},
          {k < 4 ? k[7:0] : 8'h10, 24'h0});
        cmpV({sink.got[b+4], sink.got[b+5], sink.got[b+6], sink.got[b+7]},
          k < 4 ? 32'h48 : 32'h100);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    {seed, num_errors, n_checks, cyc} = {32'h1388d685, 96'h0};
    wantResp = `RESP_OKAY;
    {arst_n, cmdValid, ewStart, ewValid, stall, cmdMode, cmdBufId, cmdNexus, ewData} = '0;
    {cmdOffset, cmdAllocLen, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    axiRd(4'h0);
    cmpV(rd, `HIST_MAXLEN_RST);
    axiWr(4'h4, 32'h5a);
    axiRd(4'h4);
    cmpV(rd, 32'h5a);
    stall <= 1'b1;
    runCmd(`MODE_ECHO_RD, 8'h0, 24'h0, 24'h10, 8'h07);
    cmpSt(1'b1, `ASC_NO_ECHO);
    runCmd(`MODE_EXP_COMM, 8'h0, 24'h0, 24'h10, 8'h07);
    cmpSt(1'b1, `ASC_NO_ECHO);
    echoWrite(5);
    echoRead(`MODE_ECHO_RD, 24'hffa503);
    echoRead(`MODE_EXP_COMM, 24'h000010);
    echoWrite(70);
    axiRd(4'hc);
    cmpV(rd, 32'h40);
    wantResp = `RESP_SLVERR;
    axiRd(4'h2);
    cmpV(rd, 32'h0);
    axiWr(4'h6, 32'h1);
    wantResp = `RESP_OKAY;
    repeat (4) begin
      r = rnd();
      echoWrite(int'(r[5:0]) + 1);
      echoRead(r[8] ? `MODE_EXP_COMM : `MODE_ECHO_RD, {r[31:16], 8'(r[15:9] % 65)});
    end
    runCmd(`MODE_ECHO_DESC, 8'h0, 24'h0, 24'h4, 8'h07);
    ex = '{8'h00, 8'h00, 8'h00, 8'h40};
    cmpRx();
    runCmd(`MODE_ECHO_DESC, 8'h0, 24'h0, 24'h2, 8'h07);
    ex = '{8'h00, 8'h00};
    cmpRx();
    runCmd(`MODE_ECHO_DESC, 8'h0, 24'h0, 24'h0, 8'h07);
    ex.delete();
    cmpRx();
    cmpSt(1'b0, 8'h0);
    foreach (badModes[i]) begin
      runCmd(badModes[i], 8'h0, 24'h0, 24'h4, 8'h07);
      cmpSt(1'b1, `ASC_INV_FIELD);
    end
    hist(8'h00, 24'h0, 8'h01);
    chkDir();
    hist(8'h00, 24'h1, 8'h01);
    cmpSt(1'b1, `ASC_INV_FIELD);
    hist(8'h03, 24'h0, 8'h01);
    chkDir();
    axiRd(4'h8);
    cmpV(rd & 32'hff07, 32'h0107);
    hist(8'h10, 24'hf0, 8'h01);
    cmpV(sink.got.size(), 16);
    foreach (sink.got[i]) cmpV(sink.got[i] ^ sink.got[0], i);
    hist(8'h10, 24'h100, 8'h01);
    cmpSt(1'b1, `ASC_INV_FIELD);
    hist(8'h10, 24'h0, 8'h02);
    cmpSt(1'b1, `ASC_OP_BUSY);
    hist(8'h02, 24'h0, 8'h02);
    chkDir();
    hist(8'h05, 24'h0, 8'h02);
    cmpSt(1'b1, `ASC_INV_FIELD);
    hist(8'h00, 24'h0, 8'h01);
    cmpSt(1'b1, `ASC_OP_BUSY);
    hist(8'hfe, 24'h123, 8'h02);
    cmpSt(1'b0, 8'h0);
    hist(8'hff, 24'h456, 8'h01);
    cmpV(doneCheck, 32'h0);
    cmpV(sink.got.size(), 32'h0);
    axiRd(4'h8);
    cmpV(rd & 32'h7, 32'h1);
    echoRead(`MODE_ECHO_RD, 24'h40);
    axiWr(4'h0, 32'h18);
    hist(8'h10, 24'h10, 8'h03);
    cmpV(sink.got.size(), 8);
    conclude();
  end
endmodule
